// ===== pkg/wdt_pkg.sv
// shared constants and types of the watchdog reset timer
`default_nettype none

package wdt_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [15:0] WDT_SERVICE_ADDR = 16'hffff;
	localparam logic [15:0] WDT_COUNT_ADDR   = 16'hfe00;
	localparam logic [15:0] WDT_CAUSE_ADDR   = 16'hfe01;
	localparam int          WDT_CAUSE_BIT    = 0;
	localparam logic [7:0]  WDT_RDATA_RST    = 8'h00;
	localparam logic [7:0]  WDT_CAUSE_RST    = 8'h00;

	// ---------------------------------------------------------------
	// counter chain and timing, in oscillator clocks
	// ---------------------------------------------------------------
	localparam int WDT_PRE_W      = 13;
	localparam int WDT_CNT_W      = 6;
	localparam int WDT_PRE_KEEP   = 4;
	localparam int WDT_CHAIN_W    = WDT_PRE_W + WDT_CNT_W;
	localparam int WDT_TIMEOUT_CYC = 2**18 - 2**4;
	localparam int WDT_PULSE_CYC  = 32;
	localparam int WDT_POR_CYC    = 4096;
	localparam int WDT_POR_W      = $clog2(WDT_POR_CYC);

	// reset pulse sequencer states
	typedef enum logic [0:0] {
		WDT_SEQ_IDLE  = 1'b0,
		WDT_SEQ_DRIVE = 1'b1
	} wdt_seq_t;

endpackage : wdt_pkg

`default_nettype wire

// ===== core/wdt_prescaler.sv
// free-running prescaler with whole and upper-bit clears
`timescale 1ns/10ps
`default_nettype none

module wdt_prescaler #(
	parameter int W    = 13,
	parameter int KEEP = 4
) (
	input  wire logic         ref_clk,
	input  wire logic         sys_rst,
	input  wire logic         en,
	input  wire logic         clr_all,
	input  wire logic         clr_hi,
	output var  logic [W-1:0] cnt_q,
	output wire logic         carry
);
	logic [W-1:0] inc_w;
	logic [W-1:0] cnt_d;

	// clear of every bit beats the partial clear, which beats counting above the low KEEP bits
	assign inc_w = en ? W'(cnt_q + 1'b1) : cnt_q;
	assign cnt_d = clr_all ? '0 : (clr_hi ? {{(W-KEEP){1'b0}}, inc_w[KEEP-1:0]} : inc_w);
	assign carry = en && (&cnt_q);

	// counting register
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end
endmodule // wdt_prescaler

`default_nettype wire

// ===== core/wdt_pulse.sv
// fixed-length reset pulse sequencer for the open-drain reset pin
`timescale 1ns/10ps
`default_nettype none

module wdt_pulse
	import wdt_pkg::*;
#(
	parameter int LEN = 32
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output var  logic drive_n_q,
	output var  logic done_q
);
	localparam int CW = $clog2(LEN);

	wdt_seq_t      state_q;
	logic [CW-1:0] cnt_q;
	logic          last_w;

	assign last_w = (cnt_q == CW'(LEN - 1));

	// pin held low for exactly LEN clocks, done flags the cycle after
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q   <= WDT_SEQ_IDLE;
			cnt_q     <= '0;
			drive_n_q <= 1'b1;
			done_q    <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				WDT_SEQ_IDLE:
				begin
					cnt_q <= '0;
					if (start)
					begin
						state_q   <= WDT_SEQ_DRIVE;
						drive_n_q <= 1'b0;
					end
				end
				WDT_SEQ_DRIVE:
				begin
					cnt_q <= CW'(cnt_q + 1'b1);
					if (last_w)
					begin
						state_q   <= WDT_SEQ_IDLE;
						drive_n_q <= 1'b1;
						done_q    <= 1'b1;
					end
				end
				default:
				begin
					state_q   <= WDT_SEQ_IDLE;
					drive_n_q <= 1'b1;
				end
			endcase
		end
	end
endmodule // wdt_pulse

`default_nettype wire

// ===== core/wdt_top.sv
// watchdog reset timer: counter chain, service decode, reset sequencing
`timescale 1ns/10ps
`default_nettype none

module wdt_top #(
	parameter int TIMEOUT_CYC = wdt_pkg::WDT_TIMEOUT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output var  logic [7:0]  bus_rdata,
	input  wire logic [7:0]  reset_vec_lo,
	input  wire logic        internal_rst,
	input  wire logic        vec_fetch,
	input  wire logic        watchdog_disable,
	input  wire logic        stop_mode,
	input  wire logic        monitor_mode,
	input  wire logic        break_active,
	input  wire logic        hv_irq_pin,
	input  wire logic        hv_rst_pin,
	output var  logic        wdt_rst_req,
	output var  logic        rst_pin_out,
	output var  logic        rst_pin_oe_n
);
	import wdt_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [WDT_PRE_W-1:0]   pre_cnt;
	logic                   pre_carry;
	logic [WDT_CNT_W-1:0]   wdc_q;
	logic [WDT_CNT_W-1:0]   wdc_d;
	logic [WDT_CHAIN_W-1:0] chain_w;
	logic                   ovf_q;
	logic                   ovf_d;
	logic [WDT_POR_W-1:0]   por_cnt_q;
	logic                   por_done_q;
	logic                   por_clr;
	logic [7:0]             cause_q;
	logic [7:0]             cause_d;
	logic [7:0]             rdata_d;
	logic                   svc_wr;
	logic                   svc_rd;
	logic                   cnt_rd;
	logic                   cause_rd;
	logic                   cnt_en;
	logic                   inhibit;
	logic                   hit;
	logic                   fire;
	logic                   seq_done;
	logic                   pre_clr_all;
	logic                   wdc_clr;
	logic                   pin_drive_n;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	// the write data is ignored: any value services the watchdog
	assign svc_wr   = bus_wr && (bus_addr == WDT_SERVICE_ADDR);
	assign svc_rd   = bus_rd && (bus_addr == WDT_SERVICE_ADDR);
	assign cnt_rd   = bus_rd && (bus_addr == WDT_COUNT_ADDR);
	assign cause_rd = bus_rd && (bus_addr == WDT_CAUSE_ADDR);

	// read mux; service address shows the vector byte, never our state
	assign rdata_d = svc_rd   ? reset_vec_lo :
	                 cnt_rd   ? {{(8-WDT_CNT_W){1'b0}}, wdc_q} :
	                 cause_rd ? cause_q : 8'h00;

	// ---------------------------------------------------------------
	// enable and inhibit terms
	// ---------------------------------------------------------------
	// wait state has no input here on purpose: counting goes on
	// stop gates the prescaler clock, modelled as a count enable
	assign cnt_en = !stop_mode && !ovf_q;

	// test-voltage modes and the configuration bit block the reset
	assign inhibit = watchdog_disable
	              || (monitor_mode && (hv_irq_pin || hv_rst_pin))
	              || (break_active && hv_rst_pin);

	// ---------------------------------------------------------------
	// counter chain and timeout detect
	// ---------------------------------------------------------------
	assign chain_w = {wdc_q, pre_cnt};
	assign hit     = cnt_en && (chain_w == WDT_CHAIN_W'(TIMEOUT_CYC - 1));
	// timeout only ever becomes a reset, never an interrupt request
	assign fire    = hit && !inhibit;

	// an inhibited timeout simply restarts the chain instead of wrapping
	assign pre_clr_all = internal_rst || vec_fetch || por_clr
	                  || seq_done || (hit && inhibit);
	assign wdc_clr     = internal_rst || svc_wr || seq_done
	                  || (hit && inhibit);

	// 6-bit stage advances on prescaler carry only
	assign wdc_d = wdc_clr ? '0 :
	               (pre_carry ? WDT_CNT_W'(wdc_q + 1'b1) : wdc_q);

	// request is held until the pulse sequencer has finished
	assign ovf_d = fire ? 1'b1 : (seq_done ? 1'b0 : ovf_q);

	// cause flag: a timeout in the reading cycle wins over the clear
	assign cause_d = fire ? (cause_q | (8'h01 << WDT_CAUSE_BIT)) :
	                 (cause_rd ? 8'h00 : cause_q);

	// power-up prescaler clear after a fixed count from reset release
	assign por_clr = !por_done_q && (por_cnt_q == WDT_POR_W'(WDT_POR_CYC - 1));

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	// service write clears prescaler bits above the low four
	wdt_prescaler #(
		.W    (WDT_PRE_W),
		.KEEP (WDT_PRE_KEEP)
	) u_pre (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.en      (cnt_en),
		.clr_all (pre_clr_all),
		.clr_hi  (svc_wr),
		.cnt_q   (pre_cnt),
		.carry   (pre_carry)
	);

	wdt_pulse #(
		.LEN (WDT_PULSE_CYC)
	) u_pulse (
		.ref_clk   (ref_clk),
		.sys_rst   (sys_rst),
		.start     (fire),
		.drive_n_q (pin_drive_n),
		.done_q    (seq_done)
	);

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// watchdog counter, overflow request and cause
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wdc_q   <= '0;
			ovf_q   <= 1'b0;
			cause_q <= WDT_CAUSE_RST;
		end
		else
		begin
			wdc_q   <= wdc_d;
			ovf_q   <= ovf_d;
			cause_q <= cause_d;
		end
	end

	// power-up delay counter, stops once the clear has been issued
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			por_cnt_q  <= '0;
			por_done_q <= 1'b0;
		end
		else if (!por_done_q)
		begin
			por_cnt_q  <= WDT_POR_W'(por_cnt_q + 1'b1);
			por_done_q <= por_clr;
		end
	end

	// outputs, each from its own flip-flop
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bus_rdata    <= WDT_RDATA_RST;
			wdt_rst_req  <= 1'b0;
			rst_pin_out  <= 1'b0;
			rst_pin_oe_n <= 1'b1;
		end
		else
		begin
			bus_rdata    <= rdata_d;
			wdt_rst_req  <= ovf_d;
			rst_pin_out  <= 1'b0;
			rst_pin_oe_n <= pin_drive_n;
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence pin_low_32_s;
		##1 (rst_pin_oe_n == 1'b0) ##31 (rst_pin_oe_n == 1'b0);
	endsequence

	sequence pin_release_s;
		##1 (rst_pin_oe_n == 1'b1);
	endsequence

	// reset pin: low one cycle late (output flop), 32 cycles, then free
	property pin_pulse_p;
		fire |=> pin_low_32_s ##0 pin_release_s;
	endproperty

	pin_pulse_len_a: assert property (pin_pulse_p)
		else $error("reset pin pulse not 32 cycles");

	cause_set_a: assert property (fire |=> cause_q[WDT_CAUSE_BIT])
		else $error("cause flag not set on timeout");

	timeout_point_a: assert property (
		fire |-> (chain_w == WDT_CHAIN_W'(TIMEOUT_CYC - 1)) && $past(cnt_en))
		else $error("timeout at wrong chain value");

	svc_clear_a: assert property (
		svc_wr |=> (wdc_q == '0) && (pre_cnt[WDT_PRE_W-1:WDT_PRE_KEEP] == '0))
		else $error("service write did not clear counters");

	svc_low_keep_a: assert property (
		svc_wr && !pre_clr_all && !cnt_en
		|=> pre_cnt[WDT_PRE_KEEP-1:0] == $past(pre_cnt[WDT_PRE_KEEP-1:0]))
		else $error("service write disturbed low prescaler bits");

	// counter moves of its own on a carry or a clear; only a plain cycle shows the read
	vec_read_a: assert property (
		svc_rd && !wdc_clr && !pre_carry |=> (bus_rdata == $past(reset_vec_lo)) && $stable(wdc_q))
		else $error("service read wrong data or side effect");

	irst_clear_a: assert property (
		internal_rst |=> (wdc_q == '0) && (pre_cnt == '0))
		else $error("internal reset left counters set");

	vfetch_clear_a: assert property (vec_fetch |=> pre_cnt == '0)
		else $error("vector fetch did not clear prescaler");

	por_clear_a: assert property (
		(!por_done_q && por_cnt_q == WDT_POR_W'(WDT_POR_CYC - 1)) |=> pre_cnt == '0)
		else $error("power-up clear missing");

	inhibit_block_a: assert property (inhibit |=> !$rose(ovf_q))
		else $error("reset raised while inhibited");

	stop_freeze_a: assert property (
		stop_mode && !pre_clr_all && !svc_wr |=> $stable(pre_cnt))
		else $error("prescaler moved in stop mode");

	ovf_hold_a: assert property (
		ovf_q && !wdc_clr |=> ovf_q && $stable(wdc_q))
		else $error("overflow request dropped early");

	// ---------------------------------------------------------------
	// counter chain details
	// ---------------------------------------------------------------
	// 6-bit stage steps once per prescaler carry
	chain_step_a: assert property (
		pre_carry && !wdc_clr |=> wdc_q == WDT_CNT_W'($past(wdc_q) + 1'b1))
		else $error("6-bit stage missed a carry");

	// without a carry or clear the 6-bit stage must not move
	wdc_hold_a: assert property (
		!pre_carry && !wdc_clr |=> $stable(wdc_q))
		else $error("6-bit stage moved without carry");

	// a service leaves at most the low prescaler bits behind
	svc_restart_a: assert property (
		svc_wr && !pre_clr_all |=> chain_w < WDT_CHAIN_W'(2**WDT_PRE_KEEP))
		else $error("service did not restart the period");

	// low prescaler bits go on counting through a service
	svc_low_run_a: assert property (
		svc_wr && !pre_clr_all
		|=> pre_cnt[WDT_PRE_KEEP-1:0] == WDT_PRE_KEEP'($past(pre_cnt[WDT_PRE_KEEP-1:0]) + $past(cnt_en)))
		else $error("service write disturbed low prescaler bits");

	// no wait input exists, so any plain cycle must count
	wait_run_a: assert property (
		!stop_mode && !ovf_q && !pre_clr_all && !svc_wr |=> pre_cnt == WDT_PRE_W'($past(pre_cnt) + 1'b1))
		else $error("prescaler stalled outside stop");

	// power-up clear is issued only once
	por_once_a: assert property (
		por_done_q |-> !por_clr)
		else $error("power-up clear repeated");

	// ---------------------------------------------------------------
	// timeout and reset request
	// ---------------------------------------------------------------
	// chain frozen while a request is pending, so it cannot wrap
	no_wrap_a: assert property (
		ovf_q |-> !cnt_en)
		else $error("chain counting during request");

	// request output follows a timeout in the next cycle
	req_follow_a: assert property (
		fire |=> wdt_rst_req)
		else $error("request output missing after timeout");

	// end of pulse clears the chain and drops the request
	seq_clear_a: assert property (
		seq_done |=> (chain_w == '0) && !ovf_q)
		else $error("reset sequence end left state behind");

	// inhibited timeout restarts the chain instead of wrapping
	inhib_restart_a: assert property (
		hit && inhibit |=> chain_w == '0)
		else $error("inhibited timeout did not restart");

	// stop gates counting, so no timeout can fire
	stop_no_fire_a: assert property (
		stop_mode |-> !fire)
		else $error("timeout fired in stop mode");

	// sequencer starts driving right after a timeout
	pulse_start_a: assert property (
		fire |=> !pin_drive_n)
		else $error("pulse sequencer did not start");

	// pin enable follows the sequencer one cycle late
	oe_quiet_a: assert property (
		pin_drive_n |=> rst_pin_oe_n)
		else $error("reset pin driven while idle");

	// open-drain pin only ever pulls low
	pin_level_a: assert property (
		!rst_pin_oe_n |-> rst_pin_out == 1'b0)
		else $error("reset pin driven high");

	// ---------------------------------------------------------------
	// register reads
	// ---------------------------------------------------------------
	// cause read clears unless a timeout lands in the same cycle
	cause_clear_a: assert property (
		cause_rd && !fire |=> cause_q == 8'h00)
		else $error("cause not cleared by read");

	cause_keep_a: assert property (
		!cause_rd && !fire |=> $stable(cause_q))
		else $error("cause changed without event");

	// read data stands one cycle only, zero otherwise
	rdata_idle_a: assert property (
		!bus_rd |=> bus_rdata == 8'h00)
		else $error("read data not zero when idle");

	cnt_read_a: assert property (
		cnt_rd |=> bus_rdata == {{(8-WDT_CNT_W){1'b0}}, $past(wdc_q)})
		else $error("count read wrong");

endmodule // wdt_top

`default_nettype wire

// ===== sim/wdt_top_tb.sv
// self-checking bench for the watchdog reset timer
`timescale 1ns/10ps
`default_nettype none

module wdt_top_tb;
	import wdt_pkg::*;

	// --------------------
	// signals and counters
	// --------------------
	localparam int TO = 300;	// shortened timeout keeps the run brief
	// each entry: disable, monitor, break, hv irq, hv rst, inhibited
	localparam logic [5:0] INH [5] = '{6'h21, 6'h15, 6'h13, 6'h0b, 6'h0c};
	logic        ref_clk          = 1'b0;
	logic        sys_rst          = 1'b1;
	logic [15:0] bus_addr         = 16'h0000;
	logic [7:0]  bus_wdata        = 8'h00;
	logic        bus_wr           = 1'b0;
	logic        bus_rd           = 1'b0;
	logic [7:0]  bus_rdata;
	logic [7:0]  reset_vec_lo     = 8'h5a;
	logic        internal_rst     = 1'b0;
	logic        vec_fetch        = 1'b0;
	logic        watchdog_disable = 1'b0;
	logic        stop_mode        = 1'b0;
	logic        monitor_mode     = 1'b0;
	logic        break_active     = 1'b0;
	logic        hv_irq_pin       = 1'b0;
	logic        hv_rst_pin       = 1'b0;
	logic        wdt_rst_req;
	logic        rst_pin_out;
	logic        rst_pin_oe_n;
	int          num_errors       = 0;
	int          total_checks     = 0;

	// 50 MHz oscillator clock
	always #10 ref_clk = ~ref_clk;

	wdt_top #(.TIMEOUT_CYC(TO)) i_dut (
		.ref_clk          (ref_clk),
		.sys_rst          (sys_rst),
		.bus_addr         (bus_addr),
		.bus_wdata        (bus_wdata),
		.bus_wr           (bus_wr),
		.bus_rd           (bus_rd),
		.bus_rdata        (bus_rdata),
		.reset_vec_lo     (reset_vec_lo),
		.internal_rst     (internal_rst),
		.vec_fetch        (vec_fetch),
		.watchdog_disable (watchdog_disable),
		.stop_mode        (stop_mode),
		.monitor_mode     (monitor_mode),
		.break_active     (break_active),
		.hv_irq_pin       (hv_irq_pin),
		.hv_rst_pin       (hv_rst_pin),
		.wdt_rst_req      (wdt_rst_req),
		.rst_pin_out      (rst_pin_out),
		.rst_pin_oe_n     (rst_pin_oe_n)
	);

	// --------------------
	// access and check tasks
	// --------------------
	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	// sample a little after the edge so its updates have landed
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus_addr  <= a;
		bus_wdata <= d;
		bus_wr    <= 1'b1;
		@(posedge ref_clk);
		bus_wr    <= 1'b0;
		#1;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic read_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
		@(posedge ref_clk);
		bus_addr <= a;
		bus_rd   <= 1'b1;
		@(posedge ref_clk);
		bus_rd   <= 1'b0;
		#1;
		chk8(bus_rdata, exp, what);
	endtask

	task automatic expect_quiet(input int n);
		int bad;
		bad = 0;
		repeat (n)
		begin
			tick(1);
			bad += int'(wdt_rst_req !== 1'b0 || rst_pin_oe_n !== 1'b1);
		end
		chk8(8'(bad != 0), 8'h00, "cycles with reset");
	endtask

	// waits for a timeout inside a window, then measures the pulse
	task automatic expect_reset(input int lo, input int hi);
		int n;
		int oe;
		int rq;
		int pin;
		n = 0;
		oe = 0;
		rq = 0;
		pin = 0;
		while (wdt_rst_req !== 1'b1 && n <= hi)
		begin
			tick(1);
			n++;
		end
		chk8(8'(n > hi || n < lo), 8'h00, "timeout outside window");
		if (n > hi)
			finish_test();
		repeat (40)
		begin
			oe += int'(rst_pin_oe_n === 1'b0);
			rq += int'(wdt_rst_req === 1'b1);
			pin += int'(rst_pin_out !== 1'b0);
			tick(1);
		end
		chk8(oe[7:0], 8'd32, "pin drive cycles");
		chk8(rq[7:0], 8'd33, "request cycles");
		chk8(pin[7:0], 8'h00, "pin drive level");
		read_chk(WDT_CAUSE_ADDR, 8'h01 << WDT_CAUSE_BIT, "cause set");
		read_chk(WDT_CAUSE_ADDR, 8'h00, "cause cleared");
	endtask

	// --------------------
	// scenarios
	// --------------------
	initial
	begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1;
		chk8({5'h00, rst_pin_oe_n, rst_pin_out, wdt_rst_req}, 8'h04, "reset state");
		// service every 200 cycles with changing data; power-up clear comes at 4096
		for (int k = 0; k < 20; k++)
		begin
			expect_quiet(198);
			bus_write(WDT_SERVICE_ADDR, 8'(k * 37));
		end
		expect_reset(TO + 80, TO + 110);
		// vector reads, unmapped read and idle read data
		for (int k = 0; k < 2; k++)
		begin
			reset_vec_lo <= 8'h5a ^ 8'(k * 255);
			read_chk(WDT_SERVICE_ADDR, 8'h5a ^ 8'(k * 255), "vector byte");
		end
		read_chk(16'h1234, 8'h00, "unmapped");
		tick(1);
		chk8(bus_rdata, 8'h00, "idle rdata");
		// reads of the service place and writes beside it must not service
		bus_write(WDT_SERVICE_ADDR, 8'hff);
		read_chk(WDT_COUNT_ADDR, 8'h00, "count after service");
		for (int k = 0; k < 49; k++)
		begin
			read_chk(WDT_SERVICE_ADDR, 8'ha5, "vector byte");
			bus_write(16'hfffe, 8'h00);
		end
		expect_reset(TO - 220, TO - 190);
		// a period after a service, shortened only by the low prescaler bits it keeps
		bus_write(WDT_SERVICE_ADDR, 8'h3c);
		expect_reset(TO - 17, TO + 2);
		// stop freezes the chain partway through the period
		bus_write(WDT_SERVICE_ADDR, 8'h00);
		tick(100);
		stop_mode <= 1'b1;
		expect_quiet(1000);
		stop_mode <= 1'b0;
		expect_reset(TO - 118, TO - 96);
		// internal reset clears the whole chain, vector fetch the prescaler only; both restart the period here
		for (int k = 0; k < 2; k++)
		begin
			bus_write(WDT_SERVICE_ADDR, 8'h00);
			tick(250);
			internal_rst <= (k == 0);
			vec_fetch    <= (k == 1);
			tick(1);
			internal_rst <= 1'b0;
			vec_fetch    <= 1'b0;
			expect_reset(TO - 3, TO + 3);
		end
		// disable bit and test-voltage combinations
		for (int k = 0; k < 5; k++)
		begin
			bus_write(WDT_SERVICE_ADDR, 8'h00);
			{watchdog_disable, monitor_mode, break_active, hv_irq_pin, hv_rst_pin} <= INH[k][5:1];
			if (INH[k][0])
				expect_quiet(TO + 50);
			else
				expect_reset(TO - 18, TO + 2);
			{watchdog_disable, monitor_mode, break_active, hv_irq_pin, hv_rst_pin} <= 5'h00;
		end
		finish_test();
	end

endmodule // wdt_top_tb

`default_nettype wire
